// *** rtl/page_prog_pkg.sv ***
// Shared constants and carriers for the flash page program sequencer
package page_prog_pkg;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_COUNT = 256;
   localparam logic [7:0] SFR_BUFFER_POINTER = 8'h97;
   localparam logic [7:0] SFR_PAGE_ADDR_HIGH = 8'h96;
   localparam logic [7:0] SFR_PAGE_ADDR_LOW = 8'h95;
   localparam logic [7:0] SFR_PROGRAM_COMMAND = 8'h94;
   localparam logic [3:0] CMD_ARM = 4'hA;
   localparam logic [7:0] CMD_START = 8'h5A;
   localparam logic [7:0] BUFFER_POINTER_RESET = 8'h00;
   localparam logic [7:0] PAGE_ADDR_HIGH_RESET = 8'h00;
   localparam logic [2:0] PAGE_ADDR_LOW_RESET = 3'h0;
   localparam int LOW_ADDR_MSB = 7;
   localparam int LOW_ADDR_LSB = 5;
   localparam int LOW_CMD_MSB = 3;
   localparam logic [4:0] LAST_BYTE = 5'h1F;

   typedef struct packed {
      logic write;
      logic read;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_s;

   typedef struct packed {
      logic we;
      logic [12:0] addr;
      logic [7:0] data;
   } flash_wr_s;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_FETCH = 2'b01,
      ST_WRITE = 2'b10
   } seq_state_e;
endpackage : page_prog_pkg

// *** rtl/page_byte_index.sv ***
// Byte counter that walks the 32 positions of one page
module page_byte_index
   import page_prog_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic clear,
   input wire logic step,
   // Status
   output logic [4:0] index,
   output logic last
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         index <= 5'h00;
      end else if (clear) begin
         index <= 5'h00;
      end else if (step) begin
         index <= index + 5'h01;
      end
   end

   assign last = (index == LAST_BYTE);
endmodule : page_byte_index

// *** rtl/flash_page_program_sequencer.sv ***
// Flash page program sequencer: command registers and page copy engine
// Functional notes
// RL1 - Flash is 256 pages of 32 bytes
// RL2 - Source is a contiguous 32-byte RAM buffer
// RL3 - Firmware sets buffer pointer before starting
// RL4 - Page address bits 15:5, low bits zero
// RL5 - Start needs 0xA nibble then 0x5A byte
// RL6 - Firmware runs two NOPs after start
// RL7 - Copy 32 bytes in order into page
// RL8 - Firmware finishes setup before the start command
// RL9 - Firmware clears watchdog before page write
// RL10 - Firmware avoids vector pages and reserved top
// RL11 - Firmware avoids programming page 0 and 255
// RL12 - Nibble 0xA arms, other values disarm
// RL13 - Only 0x5A goes to command byte
// RL14 - Pointer and page address register layout
// RL15 - Unarmed start byte is ignored
// RL16 - Hold CPU fetch until page written
module flash_page_program_sequencer
   import page_prog_pkg::*;
(
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST_N,
   // Special function register access
   input wire sfr_req_s SFR_REQ,
   output logic [7:0] SFR_RDATA,
   output logic SFR_HIT,
   // Internal data RAM read port
   output logic [7:0] RAM_ADDR,
   output logic RAM_RE,
   input wire logic [7:0] RAM_RDATA,
   // Program flash write port
   output flash_wr_s FLASH_WR,
   // CPU control and status
   output logic CPU_HOLD,
   output logic BUSY,
   output logic ARMED
);
   logic [7:0] buffer_pointer;
   logic [7:0] page_addr_high;
   logic [2:0] page_addr_low;
   logic armed;
   seq_state_e state;
   seq_state_e next_state;
   logic [7:0] base_ptr;
   logic [12:0] base_page;
   logic [4:0] index;
   logic last;
   logic start;
   logic step;

   function automatic logic hit(input sfr_req_s r, input logic [7:0] a);
      hit = (r.addr == a);
   endfunction : hit

   assign start = SFR_REQ.write && hit(SFR_REQ, SFR_PROGRAM_COMMAND) &&
                  SFR_REQ.wdata == CMD_START && armed && state == ST_IDLE; // RL5 RL15

   // Software visible registers; writes ignored while busy
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         buffer_pointer <= BUFFER_POINTER_RESET;
         page_addr_high <= PAGE_ADDR_HIGH_RESET;
         page_addr_low <= PAGE_ADDR_LOW_RESET;
      end else if (SFR_REQ.write && state == ST_IDLE) begin
         if (hit(SFR_REQ, SFR_BUFFER_POINTER)) begin
            buffer_pointer <= SFR_REQ.wdata; // RL14
         end
         if (hit(SFR_REQ, SFR_PAGE_ADDR_HIGH)) begin
            page_addr_high <= SFR_REQ.wdata; // RL14
         end
         if (hit(SFR_REQ, SFR_PAGE_ADDR_LOW)) begin
            page_addr_low <= SFR_REQ.wdata[LOW_ADDR_MSB:LOW_ADDR_LSB]; // RL14
         end
      end
   end

   // Arm nibble; consumed by a start
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         armed <= 1'b0;
      end else if (start) begin
         armed <= 1'b0;
      end else if (SFR_REQ.write && hit(SFR_REQ, SFR_PAGE_ADDR_LOW)) begin
         armed <= (SFR_REQ.wdata[LOW_CMD_MSB:0] == CMD_ARM); // RL12
      end
   end

   // Read back; command fields write-only, reserved bit zero
   always_comb begin
      SFR_HIT = hit(SFR_REQ, SFR_BUFFER_POINTER) || hit(SFR_REQ, SFR_PAGE_ADDR_HIGH) ||
                hit(SFR_REQ, SFR_PAGE_ADDR_LOW) || hit(SFR_REQ, SFR_PROGRAM_COMMAND);
      SFR_RDATA = 8'h00;
      if (hit(SFR_REQ, SFR_BUFFER_POINTER)) begin
         SFR_RDATA = buffer_pointer;
      end else if (hit(SFR_REQ, SFR_PAGE_ADDR_HIGH)) begin
         SFR_RDATA = page_addr_high;
      end else if (hit(SFR_REQ, SFR_PAGE_ADDR_LOW)) begin
         SFR_RDATA = {page_addr_low, 5'h00};
      end
   end

   // Latch the operation when started
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         base_ptr <= 8'h00;
         base_page <= 13'h0000;
      end else if (start) begin
         base_ptr <= buffer_pointer; // RL2 RL3
         base_page <= {page_addr_high[4:0], page_addr_low, 5'h00}; // RL1 RL4
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: if (start) next_state = ST_FETCH;
         ST_FETCH: next_state = ST_WRITE;
         ST_WRITE: next_state = last ? ST_IDLE : ST_FETCH;
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign step = (state == ST_WRITE);

   page_byte_index u_index (
      .clk(MCLK),
      .rst_n(RST_N),
      .clear(start),
      .step(step),
      .index(index),
      .last(last)
   );

   // RAM read in FETCH, flash write of that byte in WRITE
   assign RAM_RE = (state == ST_FETCH);
   assign RAM_ADDR = base_ptr + {3'h0, index}; // RL2
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         FLASH_WR <= '0;
      end else begin
         FLASH_WR.we <= (state == ST_FETCH); // RL7
         FLASH_WR.addr <= base_page | {8'h00, index}; // RL7
         FLASH_WR.data <= RAM_RDATA;
      end
   end

   assign BUSY = (state != ST_IDLE) || FLASH_WR.we;
   assign CPU_HOLD = start || BUSY; // RL16
   assign ARMED = armed;

   sequence start_seq;
      start ##1 (state == ST_FETCH);
   endsequence

   // Fetched byte lands in flash one cycle later
   sequence byte_move_seq;
      RAM_RE ##1 (FLASH_WR.we && FLASH_WR.data == $past(RAM_RDATA));
   endsequence

   // Next fetch two cycles on, one buffer byte further
   sequence next_fetch_seq;
      ##2 (RAM_RE && RAM_ADDR == $past(RAM_ADDR, 2) + 8'h01);
   endsequence

   copy_length_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL7
      start_seq |-> ##63 (state == ST_WRITE && last) ##1 (state == ST_IDLE))
      else $error("page copy length wrong");
   unarmed_start_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL15
      (SFR_REQ.write && hit(SFR_REQ, SFR_PROGRAM_COMMAND) && !armed && state == ST_IDLE)
      |=> state == ST_IDLE)
      else $error("unarmed start accepted");
   hold_busy_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL16
      FLASH_WR.we |-> CPU_HOLD)
      else $error("cpu not held during write");
   arm_value_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL12
      (SFR_REQ.write && hit(SFR_REQ, SFR_PAGE_ADDR_LOW) && !start &&
       SFR_REQ.wdata[3:0] != CMD_ARM) |=> !armed)
      else $error("wrong nibble armed");
   page_align_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL1 RL4
      FLASH_WR.we |-> FLASH_WR.addr[12:5] == base_page[12:5])
      else $error("write left the page");
   start_cmd_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL5
      (state == ST_IDLE && $past(state) == ST_IDLE) ##1 state == ST_FETCH
      |-> $past(armed, 2) || $past(armed))
      else $error("started without arm");
   ram_order_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL2
      RAM_RE |-> RAM_ADDR == base_ptr + {3'h0, index})
      else $error("buffer address wrong");
   reg_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL14
      BUSY |=> $stable(buffer_pointer))
      else $error("pointer changed while busy");
   first_fetch_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL3
      start |=> RAM_RE && RAM_ADDR == $past(buffer_pointer))
      else $error("first fetch address wrong");
   first_write_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL4
      start |=> ##1 (FLASH_WR.we && FLASH_WR.addr[4:0] == 5'h00 &&
      FLASH_WR.addr[7:5] == $past(page_addr_low, 2) &&
      FLASH_WR.addr[12:8] == 5'($past(page_addr_high, 2))))
      else $error("page base address wrong");
   byte_move_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL7
      RAM_RE |-> byte_move_seq)
      else $error("fetched byte not written");
   ram_step_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL2
      RAM_RE && !last |-> next_fetch_seq)
      else $error("buffer address not stepped");
   flash_step_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL7
      FLASH_WR.we && FLASH_WR.addr[4:0] != LAST_BYTE |-> ##2 (FLASH_WR.we &&
      FLASH_WR.addr == $past(FLASH_WR.addr, 2) + 13'h0001))
      else $error("flash address not stepped");
   write_pulse_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL7
      FLASH_WR.we |=> !FLASH_WR.we)
      else $error("flash write longer than one cycle");
   hold_release_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL16
      FLASH_WR.we && FLASH_WR.addr[4:0] == LAST_BYTE |=> !BUSY)
      else $error("busy after last byte");
   arm_set_a: assert property (@(posedge MCLK) disable iff (!RST_N) // RL12
      SFR_REQ.write && hit(SFR_REQ, SFR_PAGE_ADDR_LOW) && SFR_REQ.wdata[3:0] == CMD_ARM
      |=> armed)
      else $error("arm nibble not taken");
endmodule : flash_page_program_sequencer

// *** tb/flash_page_program_sequencer_tb.sv ***
// Self-checking bench for the flash page program sequencer
module flash_page_program_sequencer_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import page_prog_pkg::*;
   logic MCLK, RST_N, hit, re, hold, busy, armed;
   sfr_req_s req;
   flash_wr_s fw;
   logic [7:0] rdata, ram_addr, ram_rdata;
   logic [7:0] ram [256];
   logic [7:0] flash [8192];
   int miscompares, samples_checked, cycles, seed;
   logic [7:0] pg;

   flash_page_program_sequencer u_flash_page_program_sequencer (.MCLK(MCLK), .RST_N(RST_N),
      .SFR_REQ(req), .SFR_RDATA(rdata), .SFR_HIT(hit), .RAM_ADDR(ram_addr), .RAM_RE(re),
      .RAM_RDATA(ram_rdata), .FLASH_WR(fw), .CPU_HOLD(hold), .BUSY(busy), .ARMED(armed));

   // Combinational buffer RAM and flash array
   assign ram_rdata = (re === 1'b1) ? ram[ram_addr] : 8'hXX;
   always @(posedge MCLK) if (fw.we === 1'b1) flash[fw.addr] <= fw.data;

   initial begin
      MCLK = 1'b0;
      forever #25 MCLK = ~MCLK;
   end

   always @(posedge MCLK) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done;
      end
   end

   task check(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task sfr(input logic [7:0] a, input logic [7:0] d);
      @(negedge MCLK);
      req = '{1'b1, 1'b0, a, d};
      @(negedge MCLK);
      req.write = 1'b0;
   endtask : sfr

   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge MCLK);
      req.read = 1'b1;
      req.addr = a;
      #1;
      check(rdata, exp);
      check(8'(hit), 8'(a[7:2] == 6'h25));
      req.read = 1'b0;
   endtask : rd

   task prog(input logic [7:0] p, input logic [7:0] hi, input logic [7:0] lo);
      logic [12:0] base;
      int n;
      base = {hi[4:0], lo[7:5], 5'h00};
      for (int i = 0; i < 256; i++) ram[i] = 8'($random(seed));
      flash[base + 13'd32] = 8'hC3;
      sfr(SFR_BUFFER_POINTER, p);
      sfr(SFR_PAGE_ADDR_HIGH, hi);
      sfr(SFR_PAGE_ADDR_LOW, {lo[7:5], 1'b0, CMD_ARM});
      check(8'(armed), 8'h01);
      sfr(SFR_PROGRAM_COMMAND, CMD_START);
      check(8'(hold), 8'h01);
      check(8'(armed), 8'h00);
      repeat (2) @(negedge MCLK);
      sfr(SFR_BUFFER_POINTER, ~p);
      n = 0;
      while (busy === 1'b1 && n < 200) begin
         @(negedge MCLK);
         n++;
      end
      check(8'(hold), 8'h00);
      rd(SFR_BUFFER_POINTER, p);
      rd(SFR_PAGE_ADDR_HIGH, hi);
      rd(SFR_PAGE_ADDR_LOW, {lo[7:5], 5'h00});
      for (int i = 0; i < 32; i++) check(flash[base + 13'(i)], ram[8'(p + i)]);
      check(flash[base + 13'd32], 8'hC3);
   endtask : prog

   task test_done;
      if (miscompares == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done

   initial begin
      seed = 24230;
      req = '0;
      RST_N = 1'b0;
      repeat (5) @(negedge MCLK);
      RST_N = 1'b1;
      rd(SFR_BUFFER_POINTER, BUFFER_POINTER_RESET);
      rd(SFR_PAGE_ADDR_HIGH, PAGE_ADDR_HIGH_RESET);
      rd(SFR_PAGE_ADDR_LOW, 8'h00);
      rd(8'h98, 8'h00);
      // Start byte without a valid arm nibble
      sfr(SFR_PAGE_ADDR_LOW, 8'h05);
      check(8'(armed), 8'h00);
      sfr(SFR_PROGRAM_COMMAND, CMD_START);
      check(8'(busy), 8'h00);
      sfr(SFR_PAGE_ADDR_LOW, 8'h0A);
      check(8'(armed), 8'h01);
      sfr(SFR_PAGE_ADDR_LOW, 8'h03);
      check(8'(armed), 8'h00);
      sfr(SFR_PROGRAM_COMMAND, CMD_START);
      check(8'(busy), 8'h00);
      // Page 254 with pointer wrap, the first free page, then random free pages
      prog(8'hF0, 8'h1F, 8'hC0);
      prog(8'h60, 8'h01, 8'h00);
      repeat (4) begin
         pg = 8'(8 + ($unsigned($random(seed)) % 247));
         prog(8'($random(seed)), {3'h0, pg[7:3]}, {pg[2:0], 5'h00});
      end
      // Reset in the middle of a copy, then a clean page
      sfr(SFR_PAGE_ADDR_LOW, {3'h2, 1'b0, CMD_ARM});
      sfr(SFR_PROGRAM_COMMAND, CMD_START);
      repeat (9) @(negedge MCLK);
      RST_N = 1'b0;
      #1;
      check(8'(busy), 8'h00);
      check(8'(hold), 8'h00);
      repeat (2) @(negedge MCLK);
      RST_N = 1'b1;
      check(8'(armed), 8'h00);
      rd(SFR_BUFFER_POINTER, BUFFER_POINTER_RESET);
      rd(SFR_PAGE_ADDR_HIGH, PAGE_ADDR_HIGH_RESET);
      prog(8'h20, 8'h10, 8'hA0);
      test_done;
   end
endmodule : flash_page_program_sequencer_tb
